// File: verilog/sarseq_defines.svh
/*
 * Constants for the SAR converter sequencer: register offsets, field
 * positions, reset values and conversion cycle counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SARSEQ_DEFINES_SVH
`define SARSEQ_DEFINES_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define SARSEQ_OFF_CTRL   4'h0
`define SARSEQ_OFF_CFG    4'h1
`define SARSEQ_OFF_RESL   4'h2
`define SARSEQ_OFF_RESH   4'h3

// ****************************************************************
// Field positions of the control register.
// ****************************************************************
`define SARSEQ_CTRL_PWR   7
`define SARSEQ_CTRL_TRK   6
`define SARSEQ_CTRL_DONE  5
`define SARSEQ_CTRL_BUSY  4
`define SARSEQ_CTRL_IEN   3
`define SARSEQ_CTRL_TRG_H 2
`define SARSEQ_CTRL_TRG_L 0

// ****************************************************************
// Field positions of the configuration register and reset values.
// ****************************************************************
`define SARSEQ_CFG_DIV_H  7
`define SARSEQ_CFG_DIV_L  3
`define SARSEQ_CFG_LJST   2
`define SARSEQ_CFG_SHORT  1
`define SARSEQ_CTRL_RST   8'h00
`define SARSEQ_CFG_RST    8'hF9

// ****************************************************************
// Converter clock counts per phase.
// ****************************************************************
`define SARSEQ_BITS_LONG  4'hA
`define SARSEQ_BITS_SHORT 4'h8
`define SARSEQ_TRACK_CLKS 4'h3

`endif

// File: verilog/sarseq_pkg.sv
/*
 * Types for the SAR converter sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sarseq_pkg;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    SARSEQ_IDLE  = 3'b001,
    SARSEQ_TRACK = 3'b010,
    SARSEQ_CONV  = 3'b100
  } sarseq_state_t;

  // Trigger source codes.
  typedef enum logic [2:0] {
    SARSEQ_TRG_SW   = 3'h0,
    SARSEQ_TRG_TMR0 = 3'h1,
    SARSEQ_TRG_TMR2 = 3'h2,
    SARSEQ_TRG_TMR1 = 3'h3,
    SARSEQ_TRG_PIN  = 3'h4,
    SARSEQ_TRG_TMR3 = 3'h5
  } sarseq_trg_t;

  // Timer overflow events, one pulse each, plus timer 2/3 width levels.
  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_lo;
    logic t2_hi;
    logic t2_16;
    logic t3_lo;
    logic t3_hi;
    logic t3_16;
  } sarseq_tmr_t;

  // Handshake with the analog core.
  typedef struct packed {
    logic       power;
    logic       track;
    logic       sar_clk;
    logic       start;
    logic       short_mode;
  } sarseq_ana_t;

endpackage

// File: verilog/sarseq_top.sv
/*
 * Digital sequencer for a 10-bit successive-approximation converter:
 * power gating, trigger selection, tracking control, conversion timing
 * and result formatting.
 * Assumes timer pulses are synchronous to i_clk, the trigger pin is
 * asynchronous, and the analog core presents its code when i_ana_code
 * is sampled at the end of the conversion.
 */
// Functional notes
// - Converter runs only while power bit set.
// - Power bit low means shutdown, no conversions.
// - Each finished conversion loads both result bytes.
// - Right aligned ten-bit code, full 0x03FF.
// - Left alignment shifts code to top bits.
// - Result bits without code bits read zero.
// - Short mode gives eight bits in high byte.
// - Short conversion takes two fewer converter clocks.
// - Converter clock divides system clock by field plus one.
// - Six trigger sources chosen by select field.
// - Software writes busy one to start conversion.
// - Busy high during conversion, cleared at end.
// - Busy falling edge at conversion end sets done, raises interrupt if enabled.
// - Timers 2/3 overflow choice follows their width.
// - Pin trigger starts on rising edge.
// - Delayed mode tracks three converter clocks first.
// - Without delay, conversion begins on trigger.
// - Internal triggers track whenever not converting.
// - Pin trigger tracks when delayed or pin low.
// - Short mode low byte reads zero until software writes it.
// - Divider field equals sysclk/sarclk minus one.
`timescale 1ns/100ps
`include "sarseq_defines.svh"

module sarseq_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [3:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  input  wire sarseq_pkg::sarseq_tmr_t i_tmr,
  input  wire logic                 i_ext_trig,
  input  wire logic [9:0]           i_ana_code,
  output sarseq_pkg::sarseq_ana_t   o_ana,
  output logic                      o_irq
);

  // ****************************************************************
  // Registers and state.
  // ****************************************************************
  logic [7:0]                ctrl_ff;
  logic [7:0]                cfg_ff;
  logic [7:0]                resh_ff;
  logic [7:0]                resl_ff;
  logic                      busy_ff;
  logic                      done_ff;
  logic                      irq_ff;
  logic [7:0]                rdata_ff;
  logic                      pin_s1_ff;
  logic                      pin_s2_ff;
  logic                      pin_s3_ff;
  logic [4:0]                div_cnt_ff;
  logic                      sar_clk_ff;
  logic [3:0]                ph_cnt_ff;
  logic                      short_ff;
  sarseq_pkg::sarseq_state_t state_ff;
  sarseq_pkg::sarseq_state_t nxt_state;

  logic       pwr;
  logic       dly;
  logic [2:0] trg_sel;
  logic       wr_ctrl;
  logic       sw_start;
  logic       trig;
  logic       pin_rise;
  logic       sar_tick;
  logic       conv_end;
  logic [3:0] conv_len;

  assign pwr     = ctrl_ff[`SARSEQ_CTRL_PWR];
  assign dly     = ctrl_ff[`SARSEQ_CTRL_TRK];
  assign trg_sel = ctrl_ff[`SARSEQ_CTRL_TRG_H:`SARSEQ_CTRL_TRG_L];
  assign wr_ctrl = i_wr && (i_addr == `SARSEQ_OFF_CTRL);

  // Formats a raw code into high and low bytes per mode.
  function automatic logic [15:0] fmt_result(input logic [9:0] code,
                                             input logic       short_m,
                                             input logic       ljst);
    logic [15:0] r;
    r = 16'h0000;
    if (short_m) begin
      r = {code[9:2], 8'h00};
    end else if (ljst) begin
      r = {code, 6'h00};
    end else begin
      r = {6'h00, code};
    end
    return r;
  endfunction

  // ****************************************************************
  // Trigger pin synchroniser and edge detect.
  // ****************************************************************
  // The edge detector reads only the second and third stages.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= i_ext_trig;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end
  assign pin_rise = pin_s2_ff && !pin_s3_ff;

  // ****************************************************************
  // Trigger selection.
  // ****************************************************************
  // Software start is a write of one to the busy bit while idle.
  assign sw_start = wr_ctrl && i_wdata[`SARSEQ_CTRL_BUSY];

  always_comb begin
    case (trg_sel)
      3'h0:    trig = sw_start;
      3'h1:    trig = i_tmr.t0;
      3'h2:    trig = i_tmr.t2_16 ? i_tmr.t2_hi : i_tmr.t2_lo;
      3'h3:    trig = i_tmr.t1;
      3'h4:    trig = pin_rise;
      3'h5:    trig = i_tmr.t3_16 ? i_tmr.t3_hi : i_tmr.t3_lo;
      default: trig = 1'b0;
    endcase
  end

  // ****************************************************************
  // Converter clock divider.
  // ****************************************************************
  // One converter clock spans divider+1 system clocks; the tick marks
  // its end so phase counting needs no second clock domain.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !pwr) begin
      div_cnt_ff <= 5'h00;
      sar_clk_ff <= 1'b0;
    end else if (sar_tick) begin
      div_cnt_ff <= 5'h00;
      sar_clk_ff <= 1'b0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 5'h01;
      sar_clk_ff <= (div_cnt_ff >=
                     (cfg_ff[`SARSEQ_CFG_DIV_H:`SARSEQ_CFG_DIV_L] >> 1));
    end
  end
  // A count left above a newly lowered divider ends its period at once,
  // so it does not wrap through all 32 values first.
  assign sar_tick = (div_cnt_ff >=
                     cfg_ff[`SARSEQ_CFG_DIV_H:`SARSEQ_CFG_DIV_L]);

  // ****************************************************************
  // Sequencer state machine.
  // ****************************************************************
  assign conv_len = short_ff ? `SARSEQ_BITS_SHORT
                             : `SARSEQ_BITS_LONG;
  assign conv_end = (state_ff == sarseq_pkg::SARSEQ_CONV) && sar_tick &&
                    (ph_cnt_ff == conv_len - 4'h1);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sarseq_pkg::SARSEQ_IDLE: begin
        if (pwr && trig) begin
          nxt_state = dly ? sarseq_pkg::SARSEQ_TRACK
                          : sarseq_pkg::SARSEQ_CONV;
        end
      end
      sarseq_pkg::SARSEQ_TRACK: begin
        if (sar_tick && ph_cnt_ff == `SARSEQ_TRACK_CLKS - 4'h1) begin
          nxt_state = sarseq_pkg::SARSEQ_CONV;
        end
      end
      sarseq_pkg::SARSEQ_CONV: begin
        if (conv_end) begin
          nxt_state = sarseq_pkg::SARSEQ_IDLE;
        end
      end
      default: nxt_state = sarseq_pkg::SARSEQ_IDLE;
    endcase
  end

  // Losing power aborts any conversion in flight.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !pwr) begin
      state_ff <= sarseq_pkg::SARSEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Phase counter restarts on every state change.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !pwr || nxt_state != state_ff) begin
      ph_cnt_ff <= 4'h0;
    end else if (sar_tick) begin
      ph_cnt_ff <= ph_cnt_ff + 4'h1;
    end
  end

  // Mode is frozen at the trigger so a mid-conversion write is harmless.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      short_ff <= 1'b0;
    end else if (state_ff == sarseq_pkg::SARSEQ_IDLE) begin
      short_ff <= cfg_ff[`SARSEQ_CFG_SHORT];
    end
  end

  // Busy covers tracking and converting.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !pwr) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != sarseq_pkg::SARSEQ_IDLE);
    end
  end

  // ****************************************************************
  // Done flag and interrupt.
  // ****************************************************************
  // Set wins over a software clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_ff <= 1'b0;
    end else if (busy_ff && !(nxt_state != sarseq_pkg::SARSEQ_IDLE)
                 && pwr) begin
      done_ff <= 1'b1;
    end else if (wr_ctrl) begin
      done_ff <= i_wdata[`SARSEQ_CTRL_DONE];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done_ff && ctrl_ff[`SARSEQ_CTRL_IEN];
    end
  end

  // ****************************************************************
  // Result registers.
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      resh_ff <= 8'h00;
      resl_ff <= 8'h00;
    end else if (conv_end && pwr) begin
      {resh_ff, resl_ff} <= fmt_result(i_ana_code, short_ff,
                                       cfg_ff[`SARSEQ_CFG_LJST]);
    end else if (i_wr && i_addr == `SARSEQ_OFF_RESH) begin
      resh_ff <= i_wdata;
    end else if (i_wr && i_addr == `SARSEQ_OFF_RESL) begin
      resl_ff <= i_wdata;
    end
  end

  // ****************************************************************
  // Register port.
  // ****************************************************************
  // Busy and done bits in the control word are kept separately.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_ff <= `SARSEQ_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= i_wdata & 8'hCF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_ff <= `SARSEQ_CFG_RST;
    end else if (i_wr && i_addr == `SARSEQ_OFF_CFG) begin
      cfg_ff <= {i_wdata[7:1], 1'b1};
    end
  end

  // Read data stand in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `SARSEQ_OFF_CTRL: rdata_ff <= ctrl_ff | {2'h0, done_ff,
                                                 busy_ff, 4'h0};
        `SARSEQ_OFF_CFG:  rdata_ff <= cfg_ff;
        `SARSEQ_OFF_RESL: rdata_ff <= resl_ff;
        `SARSEQ_OFF_RESH: rdata_ff <= resh_ff;
        default:          rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign o_rdata = rdata_ff;
  assign o_irq   = irq_ff;

  // ****************************************************************
  // Analog core controls.
  // ****************************************************************
  // Track except while converting; a low pin holds tracking without delay.
  always_comb begin
    o_ana.power      = pwr;
    o_ana.sar_clk    = sar_clk_ff;
    o_ana.start      = (state_ff != sarseq_pkg::SARSEQ_CONV) &&
                       (nxt_state == sarseq_pkg::SARSEQ_CONV);
    o_ana.short_mode = short_ff;
    if (trg_sel == 3'h4 && !dly) begin
      o_ana.track = pwr && state_ff == sarseq_pkg::SARSEQ_IDLE &&
                    !pin_s2_ff;
    end else begin
      o_ana.track = pwr && state_ff != sarseq_pkg::SARSEQ_CONV;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_off_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    !pwr |=> !busy_ff;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("Busy while powered off.");

  property p_done_set;
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(busy_ff) && $past(pwr) |-> done_ff;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("Done not set at busy fall.");

  property p_bad_code;
    @(posedge i_clk) disable iff (!i_rst_n)
    trg_sel > 3'h5 && state_ff == sarseq_pkg::SARSEQ_IDLE |=>
      state_ff == sarseq_pkg::SARSEQ_IDLE;
  endproperty
  a_bad_code: assert property (p_bad_code)
    else $error("Reserved trigger code started a conversion.");

  property p_short_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    conv_end && pwr && short_ff |=> resl_ff == 8'h00;
  endproperty
  a_short_low: assert property (p_short_low)
    else $error("Short result low byte not zero.");

  property p_right;
    @(posedge i_clk) disable iff (!i_rst_n)
    conv_end && pwr && !short_ff && !cfg_ff[`SARSEQ_CFG_LJST] |=>
      resh_ff[7:2] == 6'h00 && resl_ff == $past(i_ana_code[7:0]);
  endproperty
  a_right: assert property (p_right)
    else $error("Right aligned result wrong.");

  property p_sw_go;
    @(posedge i_clk) disable iff (!i_rst_n)
    pwr && sw_start && trg_sel == 3'h0 &&
    state_ff == sarseq_pkg::SARSEQ_IDLE |=> busy_ff;
  endproperty
  a_sw_go: assert property (p_sw_go)
    else $error("Software start ignored.");

  property p_no_delay;
    @(posedge i_clk) disable iff (!i_rst_n)
    pwr && trig && !dly && state_ff == sarseq_pkg::SARSEQ_IDLE |=>
      state_ff == sarseq_pkg::SARSEQ_CONV;
  endproperty
  a_no_delay: assert property (p_no_delay)
    else $error("Undelayed trigger did not convert.");

  property p_delay;
    @(posedge i_clk) disable iff (!i_rst_n)
    pwr && trig && dly && state_ff == sarseq_pkg::SARSEQ_IDLE |=>
      state_ff == sarseq_pkg::SARSEQ_TRACK;
  endproperty
  a_delay: assert property (p_delay)
    else $error("Delayed trigger skipped tracking.");

endmodule

// File: test/sarseq_far.sv
/*
 * Far-side model of the sequencer: analog core, timer overflow sources
 * and the trigger pin.
 * Assumes the bench drives its requests right after a rising i_clk edge.
 */
`timescale 1ns/100ps

module sarseq_far (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire sarseq_pkg::sarseq_ana_t i_ana,
  input  wire logic [9:0]              i_code,
  input  wire sarseq_pkg::sarseq_tmr_t i_tmr_req,
  input  wire logic                    i_pin,
  output logic      [9:0]              o_code,
  output sarseq_pkg::sarseq_tmr_t      o_tmr,
  output logic                         o_pin
);
  // ****************************************************************
  // State
  // ****************************************************************
  logic                    conv_ff;
  sarseq_pkg::sarseq_tmr_t req_ff;

  // Remembers converting and the last request so edges can be found.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      conv_ff <= 1'b0;
      req_ff  <= '0;
    end else begin
      conv_ff <= i_ana.power & ~i_ana.track;
      req_ff  <= i_tmr_req;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The code is held while converting and one cycle after; otherwise the
  // bus shows the inverse, so a stale or early sample cannot pass.
  assign o_code = (i_ana.power & (~i_ana.track | conv_ff)) ?
                  i_code : ~i_code;
  // Overflows are one-cycle pulses; width bits are plain levels.
  assign o_tmr = sarseq_pkg::sarseq_tmr_t'(
                 (i_tmr_req & ~req_ff & 8'hF6) | (i_tmr_req & 8'h09));
  assign o_pin = i_pin;
endmodule

// File: test/tb_top.sv
/*
 * Self-checking bench for the SAR sequencer: register access, triggers,
 * result formatting, timing and tracking.
 * Assumes the far-side model in sarseq_far and the defines header.
 */
`timescale 1ns/100ps
`include "sarseq_defines.svh"

module tb_top;
  logic                    i_clk, i_rst_n, i_wr, i_rd, pin, ext_trig;
  logic                    o_irq;
  logic [3:0]              i_addr;
  logic [7:0]              i_wdata, o_rdata, rv;
  logic [9:0]              code, ana_code;
  logic [33:0]             res_tab [7];
  logic [16:0]             trg_tab [14];
  sarseq_pkg::sarseq_tmr_t tmr_req, tmr;
  sarseq_pkg::sarseq_ana_t ana;
  int                      err_total, check_count, cyc, n, tl, ts, td;
  int                      starts, st;
  time                     tt;

  sarseq_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tmr(tmr), .i_ext_trig(ext_trig), .i_ana_code(ana_code),
    .o_ana(ana), .o_irq(o_irq));
  sarseq_far u_far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ana(ana),
    .i_code(code), .i_tmr_req(tmr_req), .i_pin(pin), .o_code(ana_code),
    .o_tmr(tmr), .o_pin(ext_trig));

  // ****************************************************************
  // Clock, timeout and closing report
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // A hang is cut short well above the thousand or so cycles needed.
  always @(posedge i_clk) begin
    if (ana.start === 1'b1) begin
      starts++;
    end
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_int(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (o_irq !== 1'b1 && cnt < lim) begin
      @(posedge i_clk);
      #1 cnt++;
    end
  endtask

  // Starts one conversion, times it up to the interrupt, clears done.
  task automatic conv(input logic [7:0] c, output int t);
    wr(`SARSEQ_OFF_CTRL, c);
    wait_irq(300, t);
    wr(`SARSEQ_OFF_CTRL, c & 8'hCF);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    pin = 1'b0;
    code = 10'h000;
    tmr_req = '0;
    // Entries: cfg, code, expected high byte, expected low byte.
    res_tab = '{{8'h00, 10'h3FF, 8'h03, 8'hFF},
                {8'h00, 10'h200, 8'h02, 8'h00},
                {8'h04, 10'h3FF, 8'hFF, 8'hC0},
                {8'h04, 10'h200, 8'h80, 8'h00},
                {8'h04, 10'h100, 8'h40, 8'h00},
                {8'h02, 10'h3FF, 8'hFF, 8'h00},
                {8'h06, 10'h2A5, 8'hA9, 8'h00}};
    // Entries: ctrl, timer request, interrupt expected.
    trg_tab = '{{8'h89, 8'h80, 1'b1}, {8'h8B, 8'h40, 1'b1},
                {8'h89, 8'h40, 1'b0}, {8'h8A, 8'h20, 1'b1},
                {8'h8A, 8'h10, 1'b0}, {8'h8A, 8'h18, 1'b1},
                {8'h8A, 8'h28, 1'b0}, {8'h8D, 8'h04, 1'b1},
                {8'h8D, 8'h02, 1'b0}, {8'h8D, 8'h03, 1'b1},
                {8'h8D, 8'h05, 1'b0}, {8'h8E, 8'hF6, 1'b0},
                {8'h8F, 8'hF6, 1'b0}, {8'h09, 8'h80, 1'b0}};
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;

    // Reset values, unmapped place, power low.
    wr(4'h7, 8'hFF);
    rd(`SARSEQ_OFF_CTRL, rv);
    chk8(rv, 8'h00);
    rd(`SARSEQ_OFF_CFG, rv);
    chk8(rv, 8'hF9);
    rd(`SARSEQ_OFF_RESH, rv);
    chk8(rv, 8'h00);
    rd(4'h7, rv);
    chk8(rv, 8'h00);
    chk8({7'h00, ana.power}, 8'h00);

    // Busy while converting, done at the end, interrupt and its clear.
    wr(`SARSEQ_OFF_CFG, 8'h18);
    // Power comes up first: a start write sees only the held settings.
    wr(`SARSEQ_OFF_CTRL, 8'h88);
    wr(`SARSEQ_OFF_CTRL, 8'h98);
    rd(`SARSEQ_OFF_CTRL, rv);
    chk8(rv, 8'h98);
    chk8({7'h00, ana.power}, 8'h01);
    wait_irq(300, n);
    rd(`SARSEQ_OFF_CTRL, rv);
    chk8(rv, 8'hA8);
    chk8({7'h00, o_irq}, 8'h01);
    wr(`SARSEQ_OFF_CTRL, 8'h88);
    rd(`SARSEQ_OFF_CTRL, rv);
    chk8({rv[5], o_irq}, 8'h00);
    chk8({7'h00, ana.track}, 8'h01);

    // Divided converter clock: a period of D+1 system clocks, D = 3.
    @(posedge ana.sar_clk);
    tt = $time;
    @(posedge ana.sar_clk);
    chk_int(int'(($time - tt) / 8), 4);

    // Done without interrupt enable leaves the request low.
    wr(`SARSEQ_OFF_CTRL, 8'h90);
    n = 0;
    rv = 8'h00;
    while (rv[5] !== 1'b1 && n < 40) begin
      rd(`SARSEQ_OFF_CTRL, rv);
      n++;
    end
    chk8({rv[5], o_irq}, 8'h02);
    wr(`SARSEQ_OFF_CTRL, 8'h88);

    // Result formats: alignment, short mode, zero-filled bits.
    foreach (res_tab[i]) begin
      wr(`SARSEQ_OFF_CFG, res_tab[i][33:26]);
      code <= res_tab[i][25:16];
      conv(8'h98, n);
      rd(`SARSEQ_OFF_RESH, rv);
      chk8(rv, res_tab[i][15:8]);
      rd(`SARSEQ_OFF_RESL, rv);
      chk8(rv, res_tab[i][7:0]);
      chk8({7'h00, ana.short_mode}, {7'h00, res_tab[i][27]});
    end

    // Conversion lengths with a divider of one system clock.
    wr(`SARSEQ_OFF_CFG, 8'h00);
    st = starts;
    conv(8'h98, tl);
    wr(`SARSEQ_OFF_CFG, 8'h02);
    conv(8'h98, ts);
    wr(`SARSEQ_OFF_CFG, 8'h00);
    // Delay is armed before the start, which sees the old control word.
    wr(`SARSEQ_OFF_CTRL, 8'hC8);
    conv(8'hD8, td);
    chk_int(tl - ts, 2);
    chk_int(td - tl, 3);
    chk_int(starts - st, 3);

    // Timer sources, timer widths, unused codes and power low.
    foreach (trg_tab[i]) begin
      wr(`SARSEQ_OFF_CTRL, trg_tab[i][16:9]);
      tmr_req <= trg_tab[i][8:1];
      repeat (2) @(posedge i_clk);
      tmr_req <= '0;
      wait_irq(60, n);
      chk8({7'h00, o_irq}, {7'h00, trg_tab[i][0]});
      wr(`SARSEQ_OFF_CTRL, trg_tab[i][16:9] & 8'hCF);
    end

    // Pin trigger and tracking with the pin.
    wr(`SARSEQ_OFF_CTRL, 8'h8C);
    pin <= 1'b1;
    #1 chk8({7'h00, ana.track}, 8'h01);
    wait_irq(60, n);
    chk8({7'h00, o_irq}, 8'h01);
    wr(`SARSEQ_OFF_CTRL, 8'h8C);
    #1 chk8({7'h00, ana.track}, 8'h00);
    wr(`SARSEQ_OFF_CTRL, 8'hCC);
    pin <= 1'b0;
    #1 chk8({7'h00, ana.track}, 8'h01);
    repeat (4) @(posedge i_clk);
    report_and_stop();
  end
endmodule
